// file: pkg/rcrf_map.svh
// Offsets, field positions, codes and reset values of the frame codec
`ifndef RCRF_MAP_SVH
`define RCRF_MAP_SVH
`define RCRF_DELIM 8'h7E
`define RCRF_T_RCMD 8'h17
`define RCRF_T_ROUTE 8'h21
`define RCRF_CSUM_OK 8'hFF
`define RCRF_OPT_NOACK 0
`define RCRF_OPT_APPLY 1
`define RCRF_OPT_EXTTO 6
`define RCRF_APPLY_NAME 16'h4143
`define RCRF_I_TYPE 16'h0000
`define RCRF_I_TAG 16'h0001
`define RCRF_I_D64 16'h0002
`define RCRF_I_D16 16'h000A
`define RCRF_I_OPT 16'h000C
`define RCRF_I_NAME 16'h000D
`define RCRF_I_PARAM 16'h000F
`define RCRF_A_CTRL 8'h00
`define RCRF_A_STATUS 8'h04
`define RCRF_A_D64HI 8'h08
`define RCRF_A_D64LO 8'h0C
`define RCRF_A_D16NAME 8'h10
`define RCRF_A_PEND 8'h14
`define RCRF_A_ACTIVE 8'h18
`define RCRF_A_ERRCNT 8'h1C
`define RCRF_CTRL_EN 0
`define RCRF_CTRL_APPLY 1
`define RCRF_CTRL_RST 32'h0000_0001
`endif

// file: pkg/rcrf_pkg.sv
// Types shared by the frame codec
package rcrf_pkg;
    // Wishbone classic request from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } rcrf_wb_req_s;
    // Wishbone classic answer of the slave
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } rcrf_wb_rsp_s;
    // Parser states, Gray coded along the frame
    typedef enum logic [2:0] {
        RCRF_HUNT = 3'h0,
        RCRF_LEN_HI = 3'h1,
        RCRF_LEN_LO = 3'h3,
        RCRF_BODY = 3'h2,
        RCRF_CSUM = 3'h6
    } rcrf_state_e;
endpackage : rcrf_pkg

// file: src/rcrf_codec.sv
// Receive-side frame checker and decoder with a Wishbone register file
//
// The address map and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "rcrf_map.svh"

module rcrf_codec #(
    parameter logic [15:0] MAX_LEN = 16'h0100
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Register bus
    input wire rcrf_pkg::rcrf_wb_req_s wb_i,
    output var rcrf_pkg::rcrf_wb_rsp_s wb_o,
    // Byte stream from the serial core
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_byte_i,
    // Decoded frame
    output logic cmd_valid_o,
    output logic is_read_o,
    output logic ack_suppress_o,
    output logic ext_timeout_o,
    output logic route_valid_o,
    output logic [63:0] dest64_o,
    output logic [15:0] dest16_o,
    output logic resp_req_o,
    output logic [7:0] resp_tag_o,
    output logic [31:0] active_o,
    output logic frame_err_o
);
    // ****************************************
    // Parser
    // ****************************************
    rcrf_pkg::rcrf_state_e st_r;
    logic [15:0] len_r;
    logic [15:0] idx_r;
    logic [7:0] sum_r;
    logic [7:0] type_r;
    logic [7:0] tag_r;
    logic [7:0] opt_r;
    logic [15:0] name_r;
    logic [31:0] param_r;
    logic [15:0] pcnt_r;
    logic [31:0] ctrl_r;
    logic [31:0] pend_r;
    logic [15:0] pend_name_r;
    logic [15:0] err_cnt_r;
    logic byte_ok;
    logic [15:0] len_nxt;
    logic good;
    logic bad;
    logic rcmd;
    logic wr_en;
    logic sw_apply;

    // Bytes are dropped while software keeps the parser disabled
    assign byte_ok = rx_valid_i & ctrl_r[`RCRF_CTRL_EN];
    assign len_nxt = {len_r[15:8], rx_byte_i};
    // Body sum plus checksum must come to all ones
    assign good = byte_ok && st_r == rcrf_pkg::RCRF_CSUM
        && 8'(sum_r + rx_byte_i) == `RCRF_CSUM_OK;
    assign bad = byte_ok && ((st_r == rcrf_pkg::RCRF_CSUM && !good)
        || (st_r == rcrf_pkg::RCRF_LEN_LO
        && (len_nxt == 16'h0000 || len_nxt > MAX_LEN)));
    // Short remote commands cannot hold name and options
    assign rcmd = type_r == `RCRF_T_RCMD && len_r >= `RCRF_I_PARAM;

    // Frame walk; 0x7E inside a frame is data, so resync happens only in hunt
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= rcrf_pkg::RCRF_HUNT;
            len_r <= 16'h0000;
            idx_r <= 16'h0000;
            sum_r <= 8'h00;
        end else if (byte_ok) begin
            unique case (st_r)
                rcrf_pkg::RCRF_HUNT: begin
                    if (rx_byte_i == `RCRF_DELIM) begin
                        st_r <= rcrf_pkg::RCRF_LEN_HI;
                    end
                end
                rcrf_pkg::RCRF_LEN_HI: begin
                    len_r <= {rx_byte_i, 8'h00};
                    st_r <= rcrf_pkg::RCRF_LEN_LO;
                end
                rcrf_pkg::RCRF_LEN_LO: begin
                    len_r <= len_nxt;
                    idx_r <= 16'h0000;
                    sum_r <= 8'h00;
                    if (len_nxt == 16'h0000 || len_nxt > MAX_LEN) begin
                        st_r <= rcrf_pkg::RCRF_HUNT;
                    end else begin
                        st_r <= rcrf_pkg::RCRF_BODY;
                    end
                end
                rcrf_pkg::RCRF_BODY: begin
                    sum_r <= 8'(sum_r + rx_byte_i);
                    idx_r <= 16'(idx_r + 16'h0001);
                    if (idx_r == 16'(len_r - 16'h0001)) begin
                        st_r <= rcrf_pkg::RCRF_CSUM;
                    end
                end
                rcrf_pkg::RCRF_CSUM: begin
                    st_r <= rcrf_pkg::RCRF_HUNT;
                end
            endcase
        end
    end

    // Field capture by body position; outputs follow the bytes as they land
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            type_r <= 8'h00;
            tag_r <= 8'h00;
            dest64_o <= 64'h0000_0000_0000_0000;
            dest16_o <= 16'h0000;
            opt_r <= 8'h00;
            name_r <= 16'h0000;
            param_r <= 32'h0000_0000;
            pcnt_r <= 16'h0000;
        end else if (byte_ok && st_r == rcrf_pkg::RCRF_LEN_LO) begin
            param_r <= 32'h0000_0000;
            pcnt_r <= 16'h0000;
        end else if (byte_ok && st_r == rcrf_pkg::RCRF_BODY) begin
            if (idx_r == `RCRF_I_TYPE) begin
                type_r <= rx_byte_i;
            end
            if (idx_r == `RCRF_I_TAG) begin
                tag_r <= rx_byte_i;
            end
            if (idx_r >= `RCRF_I_D64 && idx_r < `RCRF_I_D16) begin
                dest64_o <= {dest64_o[55:0], rx_byte_i};
            end
            if (idx_r >= `RCRF_I_D16 && idx_r < `RCRF_I_OPT) begin
                dest16_o <= {dest16_o[7:0], rx_byte_i};
            end
            if (idx_r == `RCRF_I_OPT) begin
                opt_r <= rx_byte_i;
            end
            if (idx_r >= `RCRF_I_NAME && idx_r < `RCRF_I_PARAM) begin
                name_r <= {name_r[7:0], rx_byte_i};
            end
            // Only the last four parameter bytes are kept
            if (idx_r >= `RCRF_I_PARAM) begin
                param_r <= {param_r[23:0], rx_byte_i};
                pcnt_r <= 16'(pcnt_r + 16'h0001);
            end
        end
    end

    // ****************************************
    // Decoded results
    // ****************************************
    // Pulses on the edge that accepts a good checksum, the error pulse on a bad length or checksum
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_valid_o <= 1'b0;
            route_valid_o <= 1'b0;
            resp_req_o <= 1'b0;
            resp_tag_o <= 8'h00;
            is_read_o <= 1'b0;
            ack_suppress_o <= 1'b0;
            ext_timeout_o <= 1'b0;
            frame_err_o <= 1'b0;
        end else begin
            cmd_valid_o <= 1'b0;
            route_valid_o <= 1'b0;
            resp_req_o <= 1'b0;
            frame_err_o <= bad;
            if (good && type_r == `RCRF_T_ROUTE) begin
                route_valid_o <= 1'b1;
            end
            if (good && rcmd) begin
                cmd_valid_o <= 1'b1;
                is_read_o <= pcnt_r == 16'h0000;
                ack_suppress_o <= opt_r[`RCRF_OPT_NOACK];
                ext_timeout_o <= opt_r[`RCRF_OPT_EXTTO];
            end
            if (good && tag_r != 8'h00) begin
                resp_req_o <= 1'b1;
                resp_tag_o <= tag_r;
            end
        end
    end

    // Pending and active setting; a write without apply only parks the value
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_r <= 32'h0000_0000;
            pend_name_r <= 16'h0000;
            active_o <= 32'h0000_0000;
        end else if (good && rcmd && name_r == `RCRF_APPLY_NAME) begin
            active_o <= pend_r;
        end else if (good && rcmd && pcnt_r != 16'h0000) begin
            pend_r <= param_r;
            pend_name_r <= name_r;
            if (opt_r[`RCRF_OPT_APPLY]) begin
                active_o <= param_r;
            end
        end else if (sw_apply) begin
            active_o <= pend_r;
        end
    end

    // Saturating error count of bad lengths and checksums
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            err_cnt_r <= 16'h0000;
        end else if (bad && err_cnt_r != 16'hFFFF) begin
            err_cnt_r <= 16'(err_cnt_r + 16'h0001);
        end
    end

    // ****************************************
    // Wishbone slave
    // ****************************************
    // Writes land on the edge that sees ack high, as the master samples it
    assign wr_en = wb_i.cyc & wb_i.stb & wb_i.we & wb_o.ack;
    assign sw_apply = wr_en && wb_i.adr == `RCRF_A_CTRL && wb_i.sel[0]
        && wb_i.dat[`RCRF_CTRL_APPLY];

    // Control register; the apply bit is a strobe and never stored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= `RCRF_CTRL_RST;
        end else if (wr_en && wb_i.adr == `RCRF_A_CTRL && wb_i.sel[0]) begin
            ctrl_r <= {31'h0000_0000, wb_i.dat[`RCRF_CTRL_EN]};
        end
    end

    // Ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_o <= '0;
        end else begin
            wb_o.ack <= wb_i.cyc & wb_i.stb & ~wb_o.ack;
            unique case (wb_i.adr)
                `RCRF_A_CTRL: wb_o.dat <= ctrl_r;
                `RCRF_A_STATUS: wb_o.dat <= {5'h00, st_r, type_r, pcnt_r};
                `RCRF_A_D64HI: wb_o.dat <= dest64_o[63:32];
                `RCRF_A_D64LO: wb_o.dat <= dest64_o[31:0];
                `RCRF_A_D16NAME: wb_o.dat <= {pend_name_r, dest16_o};
                `RCRF_A_PEND: wb_o.dat <= pend_r;
                `RCRF_A_ACTIVE: wb_o.dat <= active_o;
                `RCRF_A_ERRCNT: wb_o.dat <= {16'h0000, err_cnt_r};
                default: wb_o.dat <= 32'h0000_0000;
            endcase
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_hunt_delim: assert property (
        st_r == rcrf_pkg::RCRF_HUNT && byte_ok && rx_byte_i == `RCRF_DELIM
        |=> st_r == rcrf_pkg::RCRF_LEN_HI)
        else $error("delimiter did not start a frame");
    chk_len_zero: assert property (
        byte_ok && st_r == rcrf_pkg::RCRF_LEN_LO && len_nxt == 16'h0000
        |=> st_r == rcrf_pkg::RCRF_HUNT && frame_err_o)
        else $error("zero length accepted");
    chk_csum_bad: assert property (
        byte_ok && st_r == rcrf_pkg::RCRF_CSUM
        && 8'(sum_r + rx_byte_i) != `RCRF_CSUM_OK
        |=> !cmd_valid_o && !route_valid_o && frame_err_o)
        else $error("bad checksum accepted");
    chk_route_type: assert property (
        route_valid_o |-> $past(type_r) == `RCRF_T_ROUTE)
        else $error("route pulse for wrong type");
    chk_read_noparam: assert property (
        cmd_valid_o |-> is_read_o == ($past(pcnt_r) == 16'h0000))
        else $error("read flag wrong");
    chk_apply_now: assert property (
        cmd_valid_o && !is_read_o && $past(opt_r[`RCRF_OPT_APPLY])
        && $past(name_r) != `RCRF_APPLY_NAME |-> active_o == $past(param_r))
        else $error("apply option not taken at once");
    chk_hold_pend: assert property (
        cmd_valid_o && !is_read_o && !$past(opt_r[`RCRF_OPT_APPLY])
        && $past(name_r) != `RCRF_APPLY_NAME
        |-> $stable(active_o) && pend_r == $past(param_r))
        else $error("setting applied without apply");
    chk_ext_tmo: assert property (
        cmd_valid_o |-> ext_timeout_o == $past(opt_r[`RCRF_OPT_EXTTO]))
        else $error("extended timeout flag wrong");
    chk_resp_tag: assert property (
        resp_req_o |-> resp_tag_o != 8'h00 && resp_tag_o == $past(tag_r))
        else $error("response for zero tag");
    chk_wb_ack: assert property (
        wb_i.cyc && wb_i.stb && !wb_o.ack |=> wb_o.ack ##1 !wb_o.ack)
        else $error("ack timing wrong");
endmodule : rcrf_codec
`default_nettype wire

// file: testbench/rcrf_host_model.sv
// Host controller model that frames commands onto the byte link
`timescale 1ns/1ns
`default_nettype none
module rcrf_host_model (
    // Clock
    input wire logic clk_i,
    // Byte link
    output logic rx_valid_o,
    output logic [7:0] rx_byte_o
);
    initial begin
        rx_valid_o = 1'b0;
        rx_byte_o = 8'h00;
    end

    // One byte; strobe is held over back-to-back bytes, never dropped between them
    task automatic put(input logic [7:0] b, input int gap);
        rx_valid_o <= 1'b1;
        rx_byte_o <= b;
        @(posedge clk_i);
        if (gap > 0) begin
            rx_valid_o <= 1'b0;
            rx_byte_o <= ~b; // Idle line never repeats stale data
            repeat (gap) @(posedge clk_i);
        end
    endtask : put

    // Whole frame: delimiter, length, body, checksum (bad flips bit 0)
    task automatic send(input logic [7:0] typ, input logic [7:0] tag,
        input logic [63:0] d64, input logic [15:0] d16,
        input logic [7:0] opt, input logic [15:0] name,
        input logic [63:0] prm, input int np, input int gap,
        input logic bad);
        logic [7:0] body [0:22];
        logic [7:0] s;
        int n;
        n = 15 + np;
        body[0] = typ;
        // Route frames never ask for a response, whatever the caller gave
        body[1] = (typ == 8'h21) ? 8'h00 : tag;
        for (int i = 0; i < 8; i++) body[2+i] = d64[63-8*i -: 8];
        body[10] = d16[15:8];
        body[11] = d16[7:0];
        body[12] = opt & 8'h43;
        body[13] = name[15:8];
        body[14] = name[7:0];
        for (int i = 0; i < np; i++) body[15+i] = prm[8*(np-1-i) +: 8];
        s = 8'h00;
        for (int i = 0; i < n; i++) s = s + body[i];
        put(8'h7E, gap);
        put(8'(n >> 8), gap);
        put(8'(n), gap);
        for (int i = 0; i < n; i++) put(body[i], gap);
        put((8'hFF - s) ^ {7'h00, bad}, 0);
        rx_valid_o <= 1'b0;
        rx_byte_o <= ~rx_byte_o;
    endtask : send
endmodule : rcrf_host_model
`default_nettype wire

// file: testbench/tb.sv
// Self-checking bench for the frame codec
`timescale 1ns/1ns
`default_nettype none
`include "rcrf_map.svh"
module tb;
    localparam logic [63:0] D64 = 64'h0013A200_40401122;
    logic clk;
    logic rst_i;
    rcrf_pkg::rcrf_wb_req_s wb_i;
    rcrf_pkg::rcrf_wb_rsp_s wb_o;
    logic rx_valid;
    logic [7:0] rx_byte;
    logic cmd_v, is_rd, ack_sup, ext_to, route_v, resp_v, err_v;
    logic [63:0] d64;
    logic [15:0] d16;
    logic [7:0] rtag;
    logic [31:0] act;
    int n_errors = 0;
    int n_tests = 0;
    int n_cmd = 0, n_route = 0, n_resp = 0, n_err = 0;

    // ************
    // Clock, design and host
    // ************
    initial clk = 1'b0;
    always #25 clk = ~clk;
    rcrf_codec #(.MAX_LEN(16'h0014)) uut (.clk_i(clk), .rst_i(rst_i),
        .wb_i(wb_i), .wb_o(wb_o), .rx_valid_i(rx_valid),
        .rx_byte_i(rx_byte), .cmd_valid_o(cmd_v), .is_read_o(is_rd),
        .ack_suppress_o(ack_sup), .ext_timeout_o(ext_to),
        .route_valid_o(route_v), .dest64_o(d64), .dest16_o(d16),
        .resp_req_o(resp_v), .resp_tag_o(rtag), .active_o(act),
        .frame_err_o(err_v));
    rcrf_host_model host (.clk_i(clk), .rx_valid_o(rx_valid),
        .rx_byte_o(rx_byte));

    // Pulses are tallied so each frame is judged after it ends
    always @(posedge clk) begin
        if (cmd_v === 1'b1) n_cmd++;
        if (route_v === 1'b1) n_route++;
        if (resp_v === 1'b1) n_resp++;
        if (err_v === 1'b1) n_err++;
    end

    // ************
    // Tasks
    // ************
    // Wide enough for the 80-bit address pair in one compare
    task automatic check(input string what, input logic [127:0] seen,
        input logic [127:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Classic cycle: hold until ack is sampled high, then release
    task automatic wb(input logic we, input logic [7:0] adr,
        input logic [31:0] dat, output logic [31:0] q);
        wb_i <= '{1'b1, 1'b1, we, adr, 4'hF, dat};
        @(posedge clk);
        // No local limit: only the watchdog may end a hung wait
        while (wb_o.ack !== 1'b1) begin
            @(posedge clk);
        end
        q = wb_o.dat;
        wb_i <= '0;
        @(posedge clk);
    endtask : wb

    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, adr, 32'h0, q);
        check("register", {56'h0, adr} << 32 | q, {56'h0, adr} << 32 | exp);
    endtask : rd_chk

    // Exp holds pulse counts {cmd, route, response, error}
    task automatic frame(input logic [7:0] typ, input logic [7:0] tag,
        input logic [7:0] opt, input logic [15:0] a16,
        input logic [15:0] name, input logic [63:0] prm, input int np,
        input int gap, input logic bad, input logic [3:0] exp);
        int b[4];
        b = '{n_cmd, n_route, n_resp, n_err};
        host.send(typ, tag, D64, a16, opt, name, prm, np, gap, bad);
        repeat (3) @(posedge clk);
        check("pulses", {4'(n_cmd - b[0]), 4'(n_route - b[1]),
            4'(n_resp - b[2]), 4'(n_err - b[3])},
            {3'h0, exp[3], 3'h0, exp[2], 3'h0, exp[1], 3'h0, exp[0]});
    endtask : frame

    task automatic end_sim;
        $display("Tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim

    // ************
    // Tests
    // ************
    initial begin
        logic [31:0] q;
        wb_i = '0;
        rst_i = 1'b1;
        repeat (8) @(posedge clk);
        rst_i <= 1'b0;
        @(posedge clk);
        rd_chk(`RCRF_A_CTRL, `RCRF_CTRL_RST);
        rd_chk(`RCRF_A_ERRCNT, 32'h0);
        rd_chk(8'h20, 32'h0);
        // Write applied at once, 0x7E inside the body is data
        frame(8'h17, 8'h01, 8'h02, 16'h7E01, 16'h4248,
            64'h11223344, 4, 0, 1'b0, 4'hA);
        check("write", {is_rd, rtag, act}, {1'b0, 8'h01, 32'h11223344});
        check("dest", {d64, d16}, {D64, 16'h7E01});
        rd_chk(`RCRF_A_D64LO, D64[31:0]);
        // Query with no-ack and extended timeout options
        frame(8'h17, 8'h00, 8'h41, 16'hFFFE, 16'h4248,
            64'h0, 0, 0, 1'b0, 4'h8);
        check("query", {is_rd, ack_sup, ext_to}, 3'h7);
        // Slow host, write held pending until the apply command
        frame(8'h17, 8'h00, 8'h00, 16'hFFFE, 16'h4248,
            64'h55, 1, 2, 1'b0, 4'h8);
        check("pending", {ack_sup, ext_to, act}, {2'h0, 32'h11223344});
        rd_chk(`RCRF_A_PEND, 32'h55);
        frame(8'h17, 8'h00, 8'h00, 16'hFFFE, `RCRF_APPLY_NAME,
            64'h0, 0, 0, 1'b0, 4'h8);
        rd_chk(`RCRF_A_ACTIVE, 32'h55);
        // Source route request, tag zero asks for no response
        frame(8'h21, 8'h00, 8'h00, 16'h3344, 16'h0103,
            64'h0, 0, 0, 1'b0, 4'h4);
        check("route", {d64, d16}, {D64, 16'h3344});
        // Bad checksum, then a length above the limit
        frame(8'h17, 8'h00, 8'h00, 16'hFFFE, 16'h4248,
            64'h0, 0, 0, 1'b1, 4'h1);
        frame(8'h17, 8'h00, 8'h00, 16'hFFFE, 16'h4248,
            64'h0102030405060708, 8, 0, 1'b0, 4'h1);
        rd_chk(`RCRF_A_ERRCNT, 32'h2);
        // Noise before the delimiter is dropped
        host.put(8'h55, 1);
        host.put(8'h17, 1);
        frame(8'h17, 8'h5A, 8'h00, 16'hFFFE, 16'h4248,
            64'h0, 0, 0, 1'b0, 4'hA);
        check("tag", rtag, 8'h5A);
        // Parser disabled: frame ignored
        wb(1'b1, `RCRF_A_CTRL, 32'h0, q);
        frame(8'h17, 8'h01, 8'h00, 16'hFFFE, 16'h4248,
            64'h0, 0, 0, 1'b0, 4'h0);
        wb(1'b1, `RCRF_A_CTRL, 32'h1, q);
        rd_chk(`RCRF_A_CTRL, 32'h1);
        // Mid-run reset clears the active setting and the error count
        rst_i <= 1'b1;
        repeat (2) @(posedge clk);
        rst_i <= 1'b0;
        @(posedge clk);
        check("reset", {act, d16, rtag}, 56'h0);
        rd_chk(`RCRF_A_ERRCNT, 32'h0);
        end_sim();
    end

    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        end_sim();
    end
endmodule : tb
`default_nettype wire
